//--- hw/gpre_master.v
// Graphics port request enqueue master: sideband port and pipelined bus path
// ****************************************************************
// ****************************************************************
`timescale 1ns/10ps
`include "gpre_defs.vh"
module gpre_master (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Configuration
  input wire sba_enable,
  input wire [1:0] rate_sel,
  input wire ext_addr_enable,
  input wire [7:0] rq_depth,
  input wire slot_release,
  // Request stream
  input wire req_valid,
  output wire req_ready,
  input wire [47:0] req_addr,
  input wire [3:0] req_cmd,
  input wire [2:0] req_len,
  // Link clock and grant from the target
  input wire link_clk,
  input wire gnt_n,
  // Sideband port
  output reg [7:0] sba_out,
  output wire sba_oe,
  output reg sb_stb_out,
  output wire sb_stb_oe,
  output reg sb_stb_n_out,
  output wire sb_stb_n_oe,
  // Multiplexed bus path
  output reg [31:0] ad_out,
  output reg ad_oe,
  output reg [3:0] cbe_n_out,
  output reg cbe_oe,
  output reg pipe_n,
  output reg req_n,
  // Status
  output reg [7:0] outstanding_reg
);

  localparam [3:0] AD_IDLE = 4'h1;
  localparam [3:0] AD_REQ = 4'h2;
  localparam [3:0] AD_PIPE = 4'h4;
  localparam [3:0] AD_TURN = 4'h8;
  localparam integer STEP_2X_CYC = `GPRE_STB2X_STEP_CYC;
  localparam integer STEP_4X_CYC = `GPRE_STB4X_STEP_CYC;
  localparam [3:0] STEP_2X = STEP_2X_CYC[3:0];
  localparam [3:0] STEP_4X = STEP_4X_CYC[3:0];

  // ****************************************************************
  // Builds the next sideband word from a request and the sticky copies
  // ****************************************************************
  function [17:0] gpre_next_word;
    input [47:0] a;
    input [3:0] c;
    input [2:0] l;
    input [12:0] s2;
    input [11:0] s3;
    input [11:0] s4;
    input [2:0] v;
    input ext;
    reg [11:0] a3;
    begin
      a3 = ext ? a[35:24] : {`GPRE_EXT_ZERO, a[31:24]};
      if (ext && (!v[2] || a[47:36] != s4)) begin
        gpre_next_word = {`GPRE_TY_T4, `GPRE_OP_T4, a[39:36], a[47:40]};
      end else if (!v[1] || a3 != s3) begin
        gpre_next_word = {`GPRE_TY_T3, `GPRE_OP_T3, `GPRE_SBA_RSV, a3};
      end else if (!v[0] || {c, a[23:15]} != s2) begin
        gpre_next_word = {`GPRE_TY_T2, `GPRE_OP_T2, c, `GPRE_SBA_RSV, a[15], a[23:16]};
      end else begin
        gpre_next_word = {`GPRE_TY_T1, `GPRE_OP_T1, a[14:3], l};
      end
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers and clock edge detect
  // ****************************************************************
  reg lclk_s1_reg;
  reg lclk_s2_reg;
  reg lclk_s3_reg;
  reg gnt_s1_reg;
  reg gnt_s2_reg;
  wire clk_rise;
  wire granted;

  always @(posedge sys_clk) begin
    if (reset) begin
      // High at reset so a high link clock gives no false rising edge
      lclk_s1_reg <= 1'b1;
      lclk_s2_reg <= 1'b1;
      lclk_s3_reg <= 1'b1;
      gnt_s1_reg <= 1'b1;
      gnt_s2_reg <= 1'b1;
    end else begin
      lclk_s1_reg <= link_clk;
      lclk_s2_reg <= lclk_s1_reg;
      lclk_s3_reg <= lclk_s2_reg;
      gnt_s1_reg <= gnt_n;
      gnt_s2_reg <= gnt_s1_reg;
    end
  end

  assign clk_rise = lclk_s2_reg & ~lclk_s3_reg;
  assign granted = ~gnt_s2_reg;

  // ****************************************************************
  // Request buffer and slot accounting
  // ****************************************************************
  wire buf_valid;
  wire [54:0] buf_data;
  wire [1:0] buf_count;
  wire pop;
  wire sba_pop;
  wire ad_pop;
  wire slot_ok;
  wire slot_after;
  wire [47:0] h_addr;
  wire [3:0] h_cmd;
  wire [2:0] h_len;

  gpre_buf2 u_buf (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_addr, req_cmd, req_len}),
    .out_valid(buf_valid),
    .out_ready(pop),
    .out_data(buf_data),
    .count(buf_count)
  );

  assign h_addr = buf_data[`GPRE_ADDR_MSB:`GPRE_ADDR_LSB];
  assign h_cmd = buf_data[`GPRE_CMD_MSB:`GPRE_CMD_LSB];
  assign h_len = buf_data[`GPRE_LEN_MSB:`GPRE_LEN_LSB];
  assign pop = sba_pop | ad_pop;
  assign slot_ok = outstanding_reg < rq_depth;
  assign slot_after = ({1'b0, outstanding_reg} + 9'h001) < {1'b0, rq_depth};

  always @(posedge sys_clk) begin
    if (reset) begin
      outstanding_reg <= 8'h00;
    end else if (pop & ~slot_release) begin
      outstanding_reg <= outstanding_reg + 8'h01;
    end else if (slot_release & ~pop & (outstanding_reg != 8'h00)) begin
      outstanding_reg <= outstanding_reg - 8'h01;
    end
  end

  // ****************************************************************
  // Sideband word selection
  // ****************************************************************
  reg [12:0] sh2_reg;
  reg [11:0] sh3_reg;
  reg [11:0] sh4_reg;
  reg [2:0] shv_reg;
  reg [15:0] w0_reg;
  reg [15:0] w1_reg;
  reg half_reg;
  reg busy_reg;
  reg load_reg;
  reg t1_first_reg;
  reg [1:0] beat_reg;
  reg [3:0] step_reg;
  wire [17:0] fw;
  wire fw_t1;
  wire fetch_a;
  wire fetch_b;
  wire take;
  wire [15:0] word_sel;
  wire is_1x;
  wire is_4x;
  wire [11:0] h_a3;

  assign is_1x = (rate_sel == `GPRE_RATE_1X);
  assign is_4x = (rate_sel == `GPRE_RATE_4X);
  assign fw = gpre_next_word(h_addr, h_cmd, h_len, sh2_reg, sh3_reg, sh4_reg,
                             shv_reg, ext_addr_enable);
  assign fw_t1 = (fw[17:16] == `GPRE_TY_T1);
  assign h_a3 = fw[11:0];
  // Words start only at a clock edge, or mid-clock for the second 4x word
  assign fetch_a = sba_enable & clk_rise & ~(is_1x & half_reg);
  assign fetch_b = sba_enable & is_4x & busy_reg & load_reg & (beat_reg == 2'h2);
  assign take = (fetch_a | fetch_b) & buf_valid & (~fw_t1 | slot_ok) &
                ~(fetch_b & t1_first_reg & fw_t1);
  assign word_sel = take ? fw[15:0] : `GPRE_SBA_IDLE;
  assign sba_pop = take & fw_t1;

  // Sticky copies mirror what the target holds
  always @(posedge sys_clk) begin
    if (reset) begin
      sh2_reg <= 13'h0000;
      sh3_reg <= 12'h000;
      sh4_reg <= 12'h000;
      shv_reg <= 3'h0;
    end else if (~sba_enable) begin
      shv_reg <= 3'h0;
    end else if (take) begin
      case (fw[17:16])
        `GPRE_TY_T4: begin
          sh4_reg <= h_addr[47:36];
          shv_reg[2] <= 1'b1;
        end
        `GPRE_TY_T3: begin
          sh3_reg <= h_a3;
          shv_reg[1] <= 1'b1;
        end
        `GPRE_TY_T2: begin
          sh2_reg <= {h_cmd, h_addr[23:15]};
          shv_reg[0] <= 1'b1;
        end
        default: begin
          shv_reg <= shv_reg;
        end
      endcase
    end
  end

  // ****************************************************************
  // Sideband serialiser and strobes
  // ****************************************************************
  assign sba_oe = 1'b1;
  assign sb_stb_oe = ~is_1x;
  assign sb_stb_n_oe = is_4x;

  always @(posedge sys_clk) begin
    if (reset) begin
      sba_out <= `GPRE_SBA_IDLE_1X;
      sb_stb_out <= 1'b1;
      sb_stb_n_out <= 1'b0;
      w0_reg <= `GPRE_SBA_IDLE;
      w1_reg <= `GPRE_SBA_IDLE;
      half_reg <= 1'b0;
      busy_reg <= 1'b0;
      load_reg <= 1'b0;
      t1_first_reg <= 1'b0;
      beat_reg <= 2'h0;
      step_reg <= 4'h0;
    end else if (is_1x) begin
      sb_stb_out <= 1'b1;
      sb_stb_n_out <= 1'b0;
      busy_reg <= 1'b0;
      load_reg <= 1'b0;
      if (clk_rise) begin
        if (half_reg) begin
          sba_out <= w0_reg[7:0];
          half_reg <= 1'b0;
        end else begin
          sba_out <= word_sel[15:8];
          w0_reg <= word_sel;
          half_reg <= take;
        end
      end
    end else if (clk_rise) begin
      // New clock period: first high half, strobes at idle level
      w0_reg <= word_sel;
      sba_out <= word_sel[15:8];
      t1_first_reg <= take & fw_t1;
      sb_stb_out <= 1'b1;
      sb_stb_n_out <= 1'b0;
      busy_reg <= 1'b1;
      load_reg <= 1'b0;
      beat_reg <= 2'h0;
      step_reg <= is_4x ? STEP_4X : STEP_2X;
      half_reg <= 1'b0;
    end else if (busy_reg) begin
      load_reg <= 1'b0;
      if (load_reg) begin
        case (beat_reg)
          2'h1: sba_out <= w0_reg[7:0];
          2'h2: begin
            w1_reg <= word_sel;
            sba_out <= word_sel[15:8];
          end
          default: sba_out <= w1_reg[7:0];
        endcase
      end
      if (step_reg == 4'h1) begin
        sb_stb_out <= ~sb_stb_out;
        if (is_4x) begin
          sb_stb_n_out <= ~sb_stb_n_out;
        end
        step_reg <= is_4x ? STEP_4X : STEP_2X;
        if (beat_reg == (is_4x ? 2'h3 : 2'h1)) begin
          busy_reg <= 1'b0;
        end else begin
          beat_reg <= beat_reg + 2'h1;
          load_reg <= 1'b1;
        end
      end else begin
        step_reg <= step_reg - 4'h1;
      end
    end
  end

  // ****************************************************************
  // Pipelined requests on the multiplexed bus
  // ****************************************************************
  reg [3:0] ad_state_reg;
  wire ad_go;
  wire ad_last;

  assign ad_go = clk_rise & (((ad_state_reg == AD_REQ) & granted) | (ad_state_reg == AD_PIPE));
  assign ad_pop = ad_go;
  assign ad_last = ~((buf_count == 2'h2) & slot_after);

  always @(posedge sys_clk) begin
    if (reset) begin
      ad_state_reg <= AD_IDLE;
      ad_out <= 32'h0000_0000;
      ad_oe <= 1'b0;
      cbe_n_out <= 4'hF;
      cbe_oe <= 1'b0;
      pipe_n <= 1'b1;
      req_n <= 1'b1;
    end else begin
      case (ad_state_reg)
        AD_IDLE: begin
          if (clk_rise & ~sba_enable & buf_valid & slot_ok) begin
            req_n <= 1'b0;
            ad_state_reg <= AD_REQ;
          end
        end
        AD_REQ, AD_PIPE: begin
          if (ad_go) begin
            ad_out <= {h_addr[31:3], h_len};
            cbe_n_out <= h_cmd;
            ad_oe <= 1'b1;
            cbe_oe <= 1'b1;
            pipe_n <= 1'b0;
            if (ad_last) begin
              req_n <= 1'b1;
              ad_state_reg <= AD_TURN;
            end else begin
              ad_state_reg <= AD_PIPE;
            end
          end
        end
        AD_TURN: begin
          if (clk_rise) begin
            pipe_n <= 1'b1;
            ad_oe <= 1'b0;
            cbe_oe <= 1'b0;
            ad_state_reg <= AD_IDLE;
          end
        end
        default: begin
          ad_state_reg <= AD_IDLE;
        end
      endcase
    end
  end

endmodule

//--- hw/gpre_defs.vh
// Constants for the graphics port request enqueue master
`ifndef GPRE_DEFS_VH
`define GPRE_DEFS_VH

// ****************************************************************
// Transfer rates
// ****************************************************************
`define GPRE_RATE_1X 2'h0
`define GPRE_RATE_2X 2'h1
`define GPRE_RATE_4X 2'h2

// ****************************************************************
// Sideband encodings
// ****************************************************************
`define GPRE_SBA_IDLE 16'hFFFF
`define GPRE_SBA_IDLE_1X 8'hFF
`define GPRE_OP_T1 1'h0
`define GPRE_OP_T2 2'h2
`define GPRE_OP_T3 3'h6
`define GPRE_OP_T4 4'hE
`define GPRE_SBA_RSV 1'h0
`define GPRE_EXT_ZERO 4'h0

// Command type codes carried beside a built word
`define GPRE_TY_T1 2'h0
`define GPRE_TY_T2 2'h1
`define GPRE_TY_T3 2'h2
`define GPRE_TY_T4 2'h3

// ****************************************************************
// Request word layout: address, bus command, length
// ****************************************************************
`define GPRE_ADDR_W 48
`define GPRE_CMD_W 4
`define GPRE_LEN_W 3
`define GPRE_REQ_W 55
`define GPRE_ADDR_MSB 54
`define GPRE_ADDR_LSB 7
`define GPRE_CMD_MSB 6
`define GPRE_CMD_LSB 3
`define GPRE_LEN_MSB 2
`define GPRE_LEN_LSB 0

// ****************************************************************
// Timing
// ****************************************************************
`define GPRE_SYS_PERIOD_PS 5000
`define GPRE_STB2X_STEP_PS 15000
`define GPRE_STB4X_STEP_PS 10000
`define GPRE_STB2X_STEP_CYC ((`GPRE_STB2X_STEP_PS / `GPRE_SYS_PERIOD_PS) < 1 ? 1 : \
  (`GPRE_STB2X_STEP_PS / `GPRE_SYS_PERIOD_PS))
`define GPRE_STB4X_STEP_CYC ((`GPRE_STB4X_STEP_PS / `GPRE_SYS_PERIOD_PS) < 1 ? 1 : \
  (`GPRE_STB4X_STEP_PS / `GPRE_SYS_PERIOD_PS))

`endif

//--- hw/gpre_buf2.v
// Two-entry request buffer with valid and ready on both sides
`timescale 1ns/10ps
module gpre_buf2 (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [54:0] in_data,
  // Draining side
  output wire out_valid,
  input wire out_ready,
  output reg [54:0] out_data,
  output wire [1:0] count
);

  reg [54:0] mem_reg [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign count = count_reg;
  assign push = in_valid & in_ready;
  assign pop = out_ready & out_valid;

  always @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
      out_data <= 55'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 2'h1;
      end
      // Head word registered; bypass when the written word becomes the head (buffer empty, or its one entry popped)
      if (push & ((count_reg == 2'h0) | ((count_reg == 2'h1) & pop))) begin
        out_data <= in_data;
      end else if (pop) begin
        out_data <= mem_reg[~rd_ptr_reg];
      end
    end
  end

endmodule

//--- sim/gpre_master_asserts.sv
// Port assertions for the request enqueue master
`timescale 1ns/10ps
module gpre_master_asserts (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Watched ports
  input wire [1:0] rate_sel,
  input wire sba_oe,
  input wire sb_stb_oe,
  input wire sb_stb_n_oe,
  input wire ad_oe,
  input wire cbe_oe,
  input wire pipe_n,
  input wire req_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  chk_sba_driven: assert property (sba_oe)
    else $error("sideband port released");
  chk_strobe_rate: assert property (sb_stb_oe == (rate_sel != 2'h0))
    else $error("strobe enable wrong for rate");
  chk_cstrobe_rate: assert property (sb_stb_n_oe == (rate_sel == 2'h2))
    else $error("second strobe enable wrong for rate");
  chk_pipe_drives_bus: assert property (!pipe_n |-> ad_oe && cbe_oe)
    else $error("pipe without bus drive");
  chk_pipe_after_req: assert property ($fell(pipe_n) |-> !$past(req_n))
    else $error("pipe without request line");
  chk_pipe_no_wait: assert property ($fell(pipe_n) |=> !pipe_n [*8])
    else $error("pipe shorter than a link clock");
  chk_last_pipe_ends: assert property (!pipe_n && req_n |-> ##[1:16] pipe_n)
    else $error("pipe held after last request");
  chk_req_no_reassert: assert property (!pipe_n && req_n |=> req_n || pipe_n)
    else $error("request line reasserted in transaction");
  chk_bus_released: assert property ($rose(pipe_n) |-> !ad_oe && !cbe_oe)
    else $error("bus held after last request");
  cover property (!pipe_n && !req_n ##1 !pipe_n && req_n);
  cover property ($fell(pipe_n) && req_n);
  cover property (sb_stb_n_oe);
endmodule

bind gpre_master gpre_master_asserts u_chk (.sys_clk(sys_clk), .reset(reset),
  .rate_sel(rate_sel), .sba_oe(sba_oe), .sb_stb_oe(sb_stb_oe), .sb_stb_n_oe(sb_stb_n_oe),
  .ad_oe(ad_oe), .cbe_oe(cbe_oe), .pipe_n(pipe_n), .req_n(req_n));

//--- sim/gpre_target_model.sv
// Core logic target model: link clock, grant, sideband decode, pipe capture
`timescale 1ns/10ps
module gpre_target_model (
  // Configuration
  input wire dec_en,
  input wire ext_en,
  input wire [1:0] rate_sel,
  input wire slow_gnt,
  // Sideband port
  input wire [7:0] sba,
  input wire sb_stb,
  input wire sb_stb_n,
  // Bus path
  input wire [31:0] ad,
  input wire [3:0] cbe_n,
  input wire ad_oe,
  input wire pipe_n,
  input wire req_n,
  // To the master
  output logic link_clk,
  output logic gnt_n,
  // Rebuilt requests and faults seen
  output logic [54:0] last_req,
  output int n_req,
  output int bad
);
  logic [7:0] hi_reg;
  logic [11:0] t4_reg, t3_reg;
  logic [12:0] t2_reg;
  logic half_reg, g1_reg, last_reg;
  int lcnt, t1_at;
  initial begin
    link_clk = 1'b0;
    gnt_n = 1'b1;
    g1_reg = 1'b1;
    half_reg = 1'b0;
    last_reg = 1'b0;
    hi_reg = 8'hff;
    n_req = 0;
    bad = 0;
    lcnt = 0;
    t1_at = -1;
    #7;
    forever #32 link_clk = ~link_clk;
  end
  // Decode one 16-bit word; a stale high half reads back as idle
  task automatic take(input logic [15:0] w);
    begin
      hi_reg = 8'hff;
      if (dec_en && w[15:8] != 8'hff) begin
        if (!w[15]) begin
          last_req = {ext_en ? {t4_reg, t3_reg[11:8]} : 16'h0, t3_reg[7:0], t2_reg[8:0],
            w[14:3], 3'h0, t2_reg[12:9], w[2:0]};
          n_req++;
          if (rate_sel == 2'h2 && t1_at == lcnt) bad++;
          t1_at = lcnt;
        end else if (w[15:14] == 2'h2) t2_reg = {w[13:10], w[7:0], w[8]};
        else if (w[15:13] == 3'h6) t3_reg = {w[11:8], w[7:0]};
        else if (w[15:12] == 4'he && ext_en) t4_reg = {w[7:0], w[11:8]};
        else bad++;
      end
    end
  endtask
  always @(posedge link_clk) begin
    lcnt++;
    gnt_n <= slow_gnt ? g1_reg : req_n;
    g1_reg <= req_n;
    if (rate_sel == 2'h0) begin
      if (half_reg) begin
        take({hi_reg, sba});
        half_reg = 1'b0;
      end else if (sba != 8'hff) begin
        hi_reg = sba;
        half_reg = 1'b1;
      end
    end
    if (last_reg && (!pipe_n || ad_oe)) bad++;
    if (!pipe_n) begin
      if (!ad_oe) bad++;
      last_req = {16'h0, ad[31:3], 3'h0, cbe_n, ad[2:0]};
      n_req++;
    end
    last_reg = !pipe_n && req_n;
  end
  always @(negedge sb_stb) if (rate_sel != 2'h0) hi_reg = sba;
  always @(posedge sb_stb) if (rate_sel == 2'h1) take({hi_reg, sba});
  always @(negedge sb_stb_n) if (rate_sel == 2'h2) take({hi_reg, sba});
endmodule

//--- sim/test_gpre_master.sv
// Self-checking testbench for the request enqueue master
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_gpre_master;
  typedef struct {logic sba; logic [1:0] rate; logic ext; logic [47:0] a; logic [3:0] c;
    logic [2:0] l; logic [47:0] x;} gpre_row_t;
  logic sys_clk, reset, sba_enable, ext_addr_enable, slot_release, req_valid, slow_gnt;
  logic [1:0] rate_sel;
  logic [7:0] rq_depth;
  logic [47:0] req_addr;
  logic [3:0] req_cmd;
  logic [2:0] req_len;
  wire link_clk, gnt_n, req_ready, sba_oe, sb_stb_out, sb_stb_oe, sb_stb_n_out, sb_stb_n_oe;
  wire ad_oe, cbe_oe, pipe_n, req_n;
  wire [7:0] sba_out, outstanding_reg;
  wire [31:0] ad_out;
  wire [3:0] cbe_n_out;
  wire [54:0] last_req;
  int n_req, bad, num_errors, checks, k, n0;
  gpre_row_t rows [6] = '{
    '{1'b1, 2'h0, 1'b0, 48'h0012_3456_78a8, 4'h6, 3'h2, 48'h0000_3456_78a8},
    '{1'b1, 2'h0, 1'b1, 48'habcd_1234_5670, 4'h7, 3'h5, 48'habcd_1234_5670},
    '{1'b1, 2'h1, 1'b1, 48'habcd_1234_9998, 4'h6, 3'h1, 48'habcd_1234_9998},
    '{1'b1, 2'h2, 1'b1, 48'h0001_ffff_0008, 4'h1, 3'h7, 48'h0001_ffff_0008},
    '{1'b1, 2'h2, 1'b0, 48'h0001_ffff_0010, 4'h1, 3'h0, 48'h0000_ffff_0010},
    '{1'b0, 2'h0, 1'b0, 48'h7777_dead_bee8, 4'h7, 3'h3, 48'h0000_dead_bee8}};
  gpre_master dut (.sys_clk(sys_clk), .reset(reset), .sba_enable(sba_enable),
    .rate_sel(rate_sel), .ext_addr_enable(ext_addr_enable), .rq_depth(rq_depth),
    .slot_release(slot_release), .req_valid(req_valid), .req_ready(req_ready),
    .req_addr(req_addr), .req_cmd(req_cmd), .req_len(req_len), .link_clk(link_clk),
    .gnt_n(gnt_n), .sba_out(sba_out), .sba_oe(sba_oe), .sb_stb_out(sb_stb_out),
    .sb_stb_oe(sb_stb_oe), .sb_stb_n_out(sb_stb_n_out), .sb_stb_n_oe(sb_stb_n_oe),
    .ad_out(ad_out), .ad_oe(ad_oe), .cbe_n_out(cbe_n_out), .cbe_oe(cbe_oe),
    .pipe_n(pipe_n), .req_n(req_n), .outstanding_reg(outstanding_reg));
  gpre_target_model tgt (.dec_en(sba_enable), .ext_en(ext_addr_enable), .rate_sel(rate_sel),
    .slow_gnt(slow_gnt), .sba(sba_out), .sb_stb(sb_stb_out), .sb_stb_n(sb_stb_n_out),
    .ad(ad_out), .cbe_n(cbe_n_out), .ad_oe(ad_oe), .pipe_n(pipe_n), .req_n(req_n),
    .link_clk(link_clk), .gnt_n(gnt_n), .last_req(last_req), .n_req(n_req), .bad(bad));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic test_done;
    begin
      $display("Comparisons %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  task automatic send(input logic [47:0] a, input logic [3:0] c, input logic [2:0] l);
    begin
      n0 = n_req;
      req_valid = 1'b1;
      req_addr = a;
      req_cmd = c;
      req_len = l;
      @(negedge sys_clk);
      req_valid = 1'b0;
      @(negedge sys_clk);
    end
  endtask
  task automatic wait_req(input int t);
    begin
      for (k = 0; k < 600 && n_req < t; k++) @(negedge sys_clk);
      if (n_req < t) begin
        num_errors++;
        $display("Error arrival expected %0d seen %0d", t, n_req);
        test_done();
      end
    end
  endtask
  task automatic free;
    begin
      slot_release = 1'b1;
      @(negedge sys_clk);
      slot_release = 1'b0;
      @(negedge sys_clk);
    end
  endtask
  task automatic chk_idle;
    begin
      `CHK("idle sba", 8'hff, sba_out)
      `CHK("pipe", 1'b1, pipe_n)
      `CHK("req", 1'b1, req_n)
      `CHK("ad drive", 1'b0, ad_oe)
      `CHK("ready", 1'b1, req_ready)
      `CHK("slots", 8'h00, outstanding_reg)
    end
  endtask
  initial begin
    reset = 1'b1;
    sba_enable = 1'b1;
    rate_sel = 2'h0;
    ext_addr_enable = 1'b0;
    rq_depth = 8'h02;
    slot_release = 1'b0;
    req_valid = 1'b0;
    req_addr = 48'h0;
    req_cmd = 4'h0;
    req_len = 3'h0;
    slow_gnt = 1'b0;
    num_errors = 0;
    checks = 0;
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    chk_idle();
    foreach (rows[i]) begin
      sba_enable = rows[i].sba;
      rate_sel = rows[i].rate;
      ext_addr_enable = rows[i].ext;
      repeat (30) @(negedge sys_clk);
      send(rows[i].a, rows[i].c, rows[i].l);
      wait_req(n0 + 1);
      `CHK("request", {rows[i].x, rows[i].c, rows[i].l}, last_req)
      `CHK("slots", 8'h01, outstanding_reg)
      free();
    end
    // No free slot: the type 1 half must wait for a release
    sba_enable = 1'b1;
    rq_depth = 8'h01;
    send(rows[0].a, rows[0].c, rows[0].l);
    wait_req(n0 + 1);
    send(rows[0].a, rows[0].c, rows[0].l);
    repeat (300) @(negedge sys_clk);
    `CHK("held", n0, n_req)
    free();
    wait_req(n0 + 1);
    `CHK("late request", {rows[0].x, rows[0].c, rows[0].l}, last_req)
    free();
    // At 4x two type 1 words may not share one clock
    rate_sel = 2'h2;
    rq_depth = 8'h02;
    repeat (30) @(negedge sys_clk);
    send(rows[4].a, rows[4].c, 3'h1);
    k = n0;
    send(rows[4].a, rows[4].c, 3'h2);
    wait_req(k + 2);
    `CHK("second t1", {rows[4].x, rows[4].c, 3'h2}, last_req)
    `CHK("slots", 8'h02, outstanding_reg)
    free();
    free();
    // Fill the buffer with no slot, then pipeline both on the bus behind a slow grant
    sba_enable = 1'b0;
    slow_gnt = 1'b1;
    rq_depth = 8'h00;
    repeat (30) @(negedge sys_clk);
    send(rows[5].a, rows[5].c, rows[5].l);
    k = n0;
    send(48'h0000_0000_4440, 4'h6, 3'h7);
    req_valid = 1'b1;
    @(negedge sys_clk);
    `CHK("full", 1'b0, req_ready)
    req_valid = 1'b0;
    rq_depth = 8'h04;
    wait_req(k + 2);
    `CHK("second", {48'h0000_0000_4440, 4'h6, 3'h7}, last_req)
    `CHK("slots", 8'h02, outstanding_reg)
    free();
    free();
    repeat (40) @(negedge sys_clk);
    `CHK("faults", 0, bad)
    reset = 1'b1;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    chk_idle();
    test_done();
  end
endmodule
